/* File: serial_cmd_regs.vh */
// Constants for the host serial command port
`ifndef SERIAL_CMD_REGS_VH
`define SERIAL_CMD_REGS_VH

// Frame and byte layout
`define BITS_PER_BYTE 8
`define BIT_CNT_W 3
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define BIT_STEP 3'h1
`define BYTE_CNT_W 2
`define BYTE_NONE 2'h0
`define BYTE_ONE 2'h1
`define BYTE_MAX 2'h2
`define BYTE_STEP 2'h1

// Reset values
`define SEL_IDLE_N 1'h1
`define SCLK_RESET 1'h0
`define BYTE_RESET 8'h00

// Reply line release after the end of a frame (upper bound)
`define MCLK_PERIOD_NS 5
`define HIZ_MAX_NS 1000
`define HIZ_MAX_CYC (`HIZ_MAX_NS / `MCLK_PERIOD_NS)

// Synchroniser depth in flip-flops
`define SYNC_STAGES 2

`endif

/* File: pin_sync.v */
// Two-stage synchroniser for the host-driven pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire mclk,
	input wire rst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule
`default_nettype wire

/* File: host_serial_command_port.v */
// Device end of the host serial command port: framing, shifting and command hand-off
`timescale 1ns/1ps
`default_nettype none
`include "serial_cmd_regs.vh"

// Summary of operation
// - Reply bytes shifted out MSB first
// - Command bits captured on serial clock rising edge
// - Command executes only when select rises
// - Either serial clock idle level works
// - Reply driven only in frame, after clock low
module host_serial_command_port (
	input wire mclk,
	input wire rst_n,
	input wire select_n,
	input wire sclk,
	input wire command_data_in,
	output wire reply_data_out,
	output wire reply_data_oe,
	input wire [7:0] reply_byte,
	output wire reply_fetch,
	output wire cmd_valid,
	output wire [1:0] cmd_count,
	output wire [7:0] cmd_byte0,
	output wire [7:0] cmd_byte1,
	output wire cmd_overrun,
	output wire busy
);

	wire [2:0] pins_raw;
	wire [2:0] pins_sync;
	wire sel_n_s;
	wire sclk_s;
	wire din_s;

	assign pins_raw = {select_n, sclk, command_data_in};

	// All three pins share one delay so data stays aligned with its clock edge
	pin_sync #(
		.WIDTH(3),
		.RESET_VAL({`SEL_IDLE_N, `SCLK_RESET, 1'b0})
	) u_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);

	assign sel_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign din_s = pins_sync[0];

	reg sclk_prev_q;
	reg sel_n_prev_q;
	reg [`BIT_CNT_W-1:0] bit_cnt_q;
	reg [`BIT_CNT_W-1:0] bit_cnt_d;
	reg [7:0] shift_in_q;
	reg [7:0] shift_in_d;
	reg [`BYTE_CNT_W-1:0] byte_cnt_q;
	reg [`BYTE_CNT_W-1:0] byte_cnt_d;
	reg [7:0] cmd0_q;
	reg [7:0] cmd0_d;
	reg [7:0] cmd1_q;
	reg [7:0] cmd1_d;
	reg overrun_q;
	reg overrun_d;
	reg rose_q;
	reg rose_d;
	reg [7:0] reply_sh_q;
	reg [7:0] reply_sh_d;
	reg oe_q;
	reg oe_d;
	reg fetch_q;
	reg fetch_d;
	reg valid_q;
	reg valid_d;
	reg [1:0] count_q;
	reg [1:0] count_d;
	reg busy_q;
	reg busy_d;

	wire sclk_rise;
	wire sclk_fall;
	wire frame_start;
	wire frame_end;
	wire selected;

	// Edges found by mclk from the synchronised copies
	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;
	assign frame_start = sel_n_prev_q & ~sel_n_s;
	assign frame_end = ~sel_n_prev_q & sel_n_s;
	assign selected = ~sel_n_s;

	always @*
	begin
		bit_cnt_d = bit_cnt_q;
		shift_in_d = shift_in_q;
		byte_cnt_d = byte_cnt_q;
		cmd0_d = cmd0_q;
		cmd1_d = cmd1_q;
		overrun_d = overrun_q;
		rose_d = rose_q;
		reply_sh_d = reply_sh_q;
		oe_d = oe_q;
		fetch_d = 1'b0;
		valid_d = 1'b0;
		count_d = count_q;
		busy_d = selected;

		if (frame_start)
		begin
			// Leftover bits of an aborted frame are dropped here
			bit_cnt_d = `BIT_FIRST;
			byte_cnt_d = `BYTE_NONE;
			shift_in_d = `BYTE_RESET;
			overrun_d = 1'b0;
			rose_d = 1'b0;
			oe_d = 1'b0;
			reply_sh_d = reply_byte;
			fetch_d = 1'b1;
		end
		else if (selected)
		begin
			// Wait for a low clock level so a high-idle clock cannot clip bit 7
			if (!oe_q && !sclk_s)
			begin
				oe_d = 1'b1;
			end

			if (sclk_rise)
			begin
				shift_in_d = {shift_in_q[6:0], din_s};
				bit_cnt_d = bit_cnt_q + `BIT_STEP;
				rose_d = 1'b1;
				if (bit_cnt_q == `BIT_LAST)
				begin
					// Bytes beyond the second are not kept
					if (byte_cnt_q == `BYTE_NONE)
					begin
						cmd0_d = {shift_in_q[6:0], din_s};
					end
					else if (byte_cnt_q == `BYTE_ONE)
					begin
						cmd1_d = {shift_in_q[6:0], din_s};
					end
					else
					begin
						overrun_d = 1'b1;
					end
					if (byte_cnt_q != `BYTE_MAX)
					begin
						byte_cnt_d = byte_cnt_q + `BYTE_STEP;
					end
				end
			end

			// Reply advances on the falling edge that follows a sampled bit,
			// so a leading falling edge from a high-idle clock is harmless
			if (sclk_fall && rose_q)
			begin
				rose_d = 1'b0;
				if (bit_cnt_q == `BIT_FIRST)
				begin
					reply_sh_d = reply_byte;
					fetch_d = 1'b1;
				end
				else
				begin
					reply_sh_d = {reply_sh_q[6:0], 1'b0};
				end
			end
		end
		else
		begin
			// Clock activity outside a frame changes nothing
			oe_d = 1'b0;
			rose_d = 1'b0;
		end

		if (frame_end)
		begin
			oe_d = 1'b0;
			if (byte_cnt_q != `BYTE_NONE)
			begin
				valid_d = 1'b1;
				count_d = byte_cnt_q;
			end
		end
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_prev_q <= `SCLK_RESET;
			sel_n_prev_q <= `SEL_IDLE_N;
			bit_cnt_q <= `BIT_FIRST;
			shift_in_q <= `BYTE_RESET;
			byte_cnt_q <= `BYTE_NONE;
			cmd0_q <= `BYTE_RESET;
			cmd1_q <= `BYTE_RESET;
			overrun_q <= 1'b0;
			rose_q <= 1'b0;
			reply_sh_q <= `BYTE_RESET;
			oe_q <= 1'b0;
			fetch_q <= 1'b0;
			valid_q <= 1'b0;
			count_q <= `BYTE_NONE;
			busy_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q <= sclk_s;
			sel_n_prev_q <= sel_n_s;
			bit_cnt_q <= bit_cnt_d;
			shift_in_q <= shift_in_d;
			byte_cnt_q <= byte_cnt_d;
			cmd0_q <= cmd0_d;
			cmd1_q <= cmd1_d;
			overrun_q <= overrun_d;
			rose_q <= rose_d;
			reply_sh_q <= reply_sh_d;
			oe_q <= oe_d;
			fetch_q <= fetch_d;
			valid_q <= valid_d;
			count_q <= count_d;
			busy_q <= busy_d;
		end
	end

	// Bit 7 of the shift register is the line; no extra stage, so no extra lag
	assign reply_data_out = reply_sh_q[7];
	assign reply_data_oe = oe_q;
	assign reply_fetch = fetch_q;
	assign cmd_valid = valid_q;
	assign cmd_count = count_q;
	assign cmd_byte0 = cmd0_q;
	assign cmd_byte1 = cmd1_q;
	assign cmd_overrun = overrun_q;
	assign busy = busy_q;

endmodule
`default_nettype wire

/* File: host_serial_command_port_assertions.sv */
// Port checker for the command port
`timescale 1ns/1ps
`default_nettype none
module host_serial_command_port_assertions (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic reply_data_out,
	input wire logic reply_data_oe,
	input wire logic cmd_valid,
	input wire logic reply_fetch,
	input wire logic busy
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	reply_shift_a: assert property (reply_data_oe && $past(reply_data_oe) && $changed(reply_data_out)
		|-> !$past(sclk, 2)) else $error("early shift");
	cmd_end_a: assert property (cmd_valid |-> select_n && $past(select_n)) else $error("early cmd");
	cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid) else $error("long cmd");
	frame_busy_a: assert property (!select_n [*5] |-> busy) else $error("no busy");
	line_free_a: assert property (select_n [*5] |-> !reply_data_oe && !busy) else $error("line held");
	line_low_a: assert property ($rose(reply_data_oe) |-> busy && !$past(sclk, 2)) else $error("early drive");
	fetch_pulse_a: assert property (reply_fetch |=> !reply_fetch) else $error("long fetch");
	cover property (cmd_valid);
	cover property ($rose(reply_data_oe));
	cover property ($rose(busy));
endmodule
bind host_serial_command_port host_serial_command_port_assertions u_chk (
	.mclk(mclk),
	.rst_n(rst_n),
	.select_n(select_n),
	.sclk(sclk),
	.reply_data_out(reply_data_out),
	.reply_data_oe(reply_data_oe),
	.cmd_valid(cmd_valid),
	.reply_fetch(reply_fetch),
	.busy(busy)
);
`default_nettype wire

/* File: host_master.sv */
// Host master model
`timescale 1ns/1ps
`default_nettype none
module host_master (
	input wire logic mclk,
	input wire logic reply_data_out,
	input wire logic reply_data_oe,
	output var logic select_n = 1'b1,
	output var logic sclk = 1'b0,
	output var logic command_data_in = 1'b0
);
	task automatic xfer(input logic [23:0] d, input int nb, input logic pol, input logic fr,
		output logic [15:0] rd);
		sclk <= pol;
		repeat (4) @(posedge mclk);
		select_n <= !fr;
		repeat (22) @(posedge mclk);
		for (int i = 0; i < nb; i++)
		begin
			sclk <= 1'b0;
			command_data_in <= d[23 - i];
			repeat (12) @(posedge mclk);
			sclk <= 1'b1;
			// A released line reads inverted so a stale bit never passes
			if (i < 16)
				rd[15 - i] = reply_data_oe ? reply_data_out : !reply_data_out;
			repeat (13) @(posedge mclk);
		end
		sclk <= pol;
		repeat (22) @(posedge mclk);
		select_n <= 1'b1;
		repeat (210) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* File: host_serial_command_port_tb.sv */
// Self-checking bench
`timescale 1ns/1ps
`default_nettype none
module host_serial_command_port_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reply_byte = 8'h00;
	logic [31:0] seed = 32'h8209;
	wire select_n, sclk, command_data_in, reply_data_out, reply_data_oe, reply_fetch, cmd_valid, cmd_overrun, busy;
	wire [1:0] cmd_count;
	wire [7:0] cmd_byte0, cmd_byte1;
	int error_cnt = 0;
	int n_checks = 0;
	int vcnt = 0;
	int fcnt = 0;
	always #2.5 mclk = ~mclk;
	// Sole driver of the reply byte: first byte while idle, second byte once the first is fetched
	always @(posedge mclk)
	begin
		vcnt <= vcnt + (cmd_valid === 1'b1);
		fcnt <= fcnt + (reply_fetch === 1'b1);
		if (reply_fetch === 1'b1)
			reply_byte <= seed[7:0];
		else if (busy !== 1'b1)
			reply_byte <= seed[31:24];
	end
	host_serial_command_port u_host_serial_command_port (
		.mclk(mclk),
		.rst_n(rst_n),
		.select_n(select_n),
		.sclk(sclk),
		.command_data_in(command_data_in),
		.reply_data_out(reply_data_out),
		.reply_data_oe(reply_data_oe),
		.reply_byte(reply_byte),
		.reply_fetch(reply_fetch),
		.cmd_valid(cmd_valid),
		.cmd_count(cmd_count),
		.cmd_byte0(cmd_byte0),
		.cmd_byte1(cmd_byte1),
		.cmd_overrun(cmd_overrun),
		.busy(busy)
	);
	host_master u_host_master (
		.mclk(mclk),
		.reply_data_out(reply_data_out),
		.reply_data_oe(reply_data_oe),
		.select_n(select_n),
		.sclk(sclk),
		.command_data_in(command_data_in)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	// Count, overrun flag and first byte that a frame of nb bits must leave behind
	function automatic logic [10:0] cmd_head(input int nb, input logic [7:0] first);
		return {nb > 15 ? 2'h2 : 2'h1, nb > 23, first};
	endfunction
	// One fetch at frame start, then one per fall after a whole byte; a high idle clock has no closing fall
	function automatic int fetches(input int nb, input logic pol, input logic fr);
		int last;
		last = pol ? nb - 1 : nb;
		if (!fr)
			return 0;
		return last > 0 ? 1 + last / 8 : 1;
	endfunction
	task automatic tally(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
		tally(got, exp, "pulse count");
	endtask
	task automatic chk_cmd(input logic [31:0] got, input logic [31:0] exp);
		tally(got, exp, "command");
	endtask
	task automatic chk_reply(input logic [31:0] got, input logic [31:0] exp);
		tally(got, exp, "reply");
	endtask
	task close_out();
		$display("%0d errors %0d checks", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic frame(input int nb, input logic pol, input logic fr);
		int v0;
		int f0;
		logic [15:0] rd;
		seed = xs(seed);
		v0 = vcnt;
		f0 = fcnt;
		u_host_master.xfer(seed[23:0], nb, pol, fr, rd);
		chk_count(vcnt - v0, fr && nb > 7);
		chk_count(fcnt - f0, fetches(nb, pol, fr));
		if (fr && nb > 7)
		begin
			chk_cmd({cmd_count, cmd_overrun, cmd_byte0}, cmd_head(nb, seed[23:16]));
			chk_reply(rd[15:8], seed[31:24]);
		end
		if (fr && nb > 15)
		begin
			chk_cmd(cmd_byte1, seed[15:8]);
			chk_reply(rd[7:0], seed[7:0]);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		for (int k = 0; k < 14; k++)
			frame(k < 4 ? 8 * k : seed % 25, k[0], k != 2);
		close_out();
	end
	initial
	begin
		#150us;
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
